// File: core/sbsd_pkg.sv
// Shared constants for the branch and special-register execute core.
// Contract
// - Opcode 100101 with bits 14-15 = 11 copies Ra into status word or float status.
// - Move-from-special copies PC, status, fault, float, slot target or version into Rd.
// - Status set ORs, clear ANDs inverted 14-bit mask; both return old status in Rd.
// - Register jumps: bits 16-20 pick relative, absolute, delayed and linking forms.
// - Break jumps go absolute, save PC in Rd and set break-active flag.
// - Opcode 100111 branches PC+Rb on signed Ra test; leading 1 means delayed.
// - Opcode 101111 does the same tests with PC plus sign-extended immediate.
// - Opcode 101110 unconditional immediate jumps, same variants as register jumps.
// - Opcode 101101 returns to Ra+imm; variants set interrupt allow or clear break.
// - Exception return sets exception allow, clears exception active, zeroes fault cause.
// - Opcodes 101000 to 101011 do OR, AND, XOR, AND-NOT with sign-extended immediate.
// - Loads at Ra+Rb or Ra+imm; byte and half fill low bits, zero the rest.
// - Stores at Ra+Rb or Ra+imm write low byte, low half or word of Rd.
// - Thirty-two 32-bit registers; register 0 reads zero and ignores writes.
// - Register file clears only on configuration load, never on resets.
// - R14 takes interrupt return, R16 break return, R17 exception return if enabled.
// - PC is executing address, resets to zero; move-to-special never changes it.
// - Status bit 0 mirrors carry bit 29; writes to bit 0 are dropped.
// - Carry takes effect at once; other writable status bits one cycle later.
// - Status bit 21 is read-only version-present flag; bits 1 to 20 reserved.
// - Bit 22 exception active, bit 23 exception allow; read/write, reset zero.
// - Bits 24 load cache enable, 25 divide zero, 26 fetch cache enable, reset zero.
// - Bit 27 is set on a stream-link control mismatch; read/write, reset zero.
// - Bit 28 break active, reset zero, set by break instruction or break input.
// - Bit 30 interrupt allow, reset zero; one lets interrupts in.
package sbsd_pkg;
	// ----------------------------------------
	// Opcodes and field positions
	// ----------------------------------------
	localparam int FLD_OP_LSB = 26;
	localparam int FLD_RD_LSB = 21;
	localparam int FLD_RA_LSB = 16;
	localparam int FLD_RB_LSB = 11;
	localparam logic [5:0] OP_SPECIAL = 6'h25;
	localparam logic [5:0] OP_JUMP_REG = 6'h26;
	localparam logic [5:0] OP_COND_REG = 6'h27;
	localparam logic [5:0] OP_OR_I = 6'h28;
	localparam logic [5:0] OP_AND_I = 6'h29;
	localparam logic [5:0] OP_XOR_I = 6'h2A;
	localparam logic [5:0] OP_ANDN_I = 6'h2B;
	localparam logic [5:0] OP_PREFIX = 6'h2C;
	localparam logic [5:0] OP_RETURN = 6'h2D;
	localparam logic [5:0] OP_JUMP_IMM = 6'h2E;
	localparam logic [5:0] OP_COND_IMM = 6'h2F;
	localparam logic [1:0] MEM_CLASS = 2'h3;
	localparam int MEM_IMM_BIT = 3;
	localparam int MEM_STORE_BIT = 2;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] SZ_BAD = 2'h3;
	// ----------------------------------------
	// Special register decode
	// ----------------------------------------
	localparam logic [1:0] SPC_MTS = 2'h3;
	localparam logic [1:0] SPC_MFS = 2'h2;
	localparam logic [1:0] SPC_BITS = 2'h0;
	localparam logic [4:0] SPC_CLEAR_FLD = 5'h01;
	localparam logic [13:0] SPR_PC = 14'h0000;
	localparam logic [13:0] SPR_MSR = 14'h0001;
	localparam logic [13:0] SPR_EAR = 14'h0003;
	localparam logic [13:0] SPR_ESR = 14'h0005;
	localparam logic [13:0] SPR_FSR = 14'h0007;
	localparam logic [13:0] SPR_BTR = 14'h000B;
	localparam logic [13:0] SPR_PVR_BASE = 14'h2000;
	localparam int PVR_COUNT = 12;
	// ----------------------------------------
	// Jump, branch and return fields
	// ----------------------------------------
	localparam int JF_DELAY = 4;
	localparam int JF_ABS = 3;
	localparam int JF_LINK = 2;
	localparam logic [4:0] JF_BREAK = 5'h0C;
	localparam int CF_DELAY = 4;
	localparam logic [2:0] CND_EQ = 3'h0;
	localparam logic [2:0] CND_NE = 3'h1;
	localparam logic [2:0] CND_LT = 3'h2;
	localparam logic [2:0] CND_LE = 3'h3;
	localparam logic [2:0] CND_GT = 3'h4;
	localparam logic [2:0] CND_GE = 3'h5;
	localparam logic [4:0] RET_INT = 5'h11;
	localparam logic [4:0] RET_BRK = 5'h12;
	localparam logic [4:0] RET_EXC = 5'h14;
	// ----------------------------------------
	// Status word bits, counted from the least significant end
	// ----------------------------------------
	localparam int MSR_IE = 1;
	localparam int MSR_C = 2;
	localparam int MSR_BIP = 3;
	localparam int MSR_FSLERR = 4;
	localparam int MSR_DZ = 6;
	localparam int MSR_EE = 8;
	localparam int MSR_EIP = 9;
	localparam int MSR_PVR = 10;
	localparam int MSR_CC = 31;
	localparam logic [31:0] MSR_RW_MASK = 32'h000003FB;
	localparam logic [31:0] MSR_RESET = 32'h00000000;
	// ----------------------------------------
	// Registers, vectors and flow
	// ----------------------------------------
	localparam logic [4:0] GPR_INT_RET = 5'h0E;
	localparam logic [4:0] GPR_BRK_RET = 5'h10;
	localparam logic [4:0] GPR_EXC_RET = 5'h11;
	localparam logic [31:0] PC_RESET = 32'h00000000;
	localparam logic [31:0] PC_STEP = 32'h00000004;
	localparam logic [31:0] VEC_INT = 32'h00000010;
	localparam logic [31:0] VEC_BRK = 32'h00000018;
	localparam logic [31:0] VEC_EXC = 32'h00000020;
	typedef enum logic [3:0] {
		S_NEXT = 4'h1,
		S_FETCH = 4'h2,
		S_EXEC = 4'h4,
		S_MEM = 4'h8
	} sbsd_state_t;
endpackage

// File: core/sbsd_core.sv
// Execute core for special moves, branches, returns, logical immediates and memory ops.
`timescale 1ns/1ps
`default_nettype none
module sbsd_core #(
	parameter bit USE_EXCEPTIONS = 1'b1,
	parameter int VERSION_REGS = 0,
	parameter logic [31:0] VERSION_WORDS [sbsd_pkg::PVR_COUNT] = '{default: 32'h00000000}
)
(
	// Clock, reset and configuration
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic cfg_load_in,
	// Instruction fetch
	output logic imem_req_out,
	output logic [31:0] imem_addr_out,
	input wire logic imem_ack_in,
	input wire logic [31:0] imem_data_in,
	// Data memory
	output logic dmem_req_out,
	output logic dmem_we_out,
	output logic [31:0] dmem_addr_out,
	output logic [31:0] dmem_wdata_out,
	output logic [3:0] dmem_be_out,
	input wire logic dmem_ack_in,
	input wire logic [31:0] dmem_rdata_in,
	// Events
	input wire logic ext_brk_in,
	input wire logic irq_in,
	input wire logic exc_req_in,
	input wire logic div_zero_in,
	input wire logic stream_mismatch_in,
	// Neighbouring special registers
	input wire logic [31:0] fault_address_in,
	input wire logic [31:0] fault_cause_in,
	output logic esr_clear_out,
	// Architectural state
	output logic [31:0] pc_out,
	output logic [31:0] msr_out,
	output logic [4:0] fsr_out
);
	import sbsd_pkg::*;

	localparam logic PVR_FLAG = (VERSION_REGS != 0);
	localparam logic [4:0] PVR_IMPL = (VERSION_REGS >= 2) ? 5'h0C : 5'(VERSION_REGS);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function automatic logic [31:0] sext16(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction

	function automatic logic cond_met(input logic [2:0] c, input logic [31:0] v);
		logic z;
		logic n;
		z = (v == 32'h00000000);
		n = v[31];
		case (c)
			CND_EQ: return z;
			CND_NE: return !z;
			CND_LT: return n;
			CND_LE: return n | z;
			CND_GT: return !n && !z;
			CND_GE: return !n;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [3:0] store_lanes(input logic [1:0] lane, input logic [1:0] sz);
		case (sz)
			SZ_BYTE: return 4'h8 >> lane;
			SZ_HALF: return lane[1] ? 4'h3 : 4'hC;
			default: return 4'hF;
		endcase
	endfunction

	function automatic logic [31:0] load_extract(input logic [31:0] w, input logic [1:0] lane,
		input logic [1:0] sz);
		case (sz)
			SZ_BYTE: return {24'h000000, w[{~lane, 3'h0} +: 8]};
			SZ_HALF: return {16'h0000, w[{~lane[1], 4'h0} +: 16]};
			default: return w;
		endcase
	endfunction

	// ----------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_b;
	logic [2:0] pin_meta_q;
	logic [2:0] pin_sync_q;

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_b = rst_sync_q[1];

	always_ff @(posedge clk_in or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pin_meta_q <= 3'h0;
			pin_sync_q <= 3'h0;
		end
		else
		begin
			pin_meta_q <= {cfg_load_in, irq_in, ext_brk_in};
			pin_sync_q <= pin_meta_q;
		end
	end

	// ----------------------------------------
	// State and decode
	// ----------------------------------------
	sbsd_state_t state_q;
	logic [31:0] pc_q, npc_q, ir_q, dly_target_q, btr_q, msr_q, msr_d;
	logic [31:0] stage_val_q, stage_mask_q;
	logic stage_valid_q, dly_pend_q, imm_hi_valid_q, exc_pend_q, esr_clear_q, imem_req_q;
	logic [15:0] imm_hi_q;
	logic [4:0] fsr_q;
	logic [31:0] gpr_q [32];
	logic dmem_req_q, dmem_we_q;
	logic [31:0] dmem_addr_q, dmem_wdata_q;
	logic [3:0] dmem_be_q;
	logic [5:0] op;
	logic [4:0] f_rd, f_ra, f_rb;
	logic [13:0] sidx;
	logic [31:0] va, vb, vd, imm32, jv, spr_val, pc_after, ev_vec;
	logic x_wen, x_jump, x_delay, x_msr_wr, x_carry_wr, x_carry_val, x_mem, x_store;
	logic x_fsr_wr, x_esr_clr, x_prefix, in_exec;
	logic [31:0] x_wd, x_target, x_msr_val, x_msr_mask, x_addr;
	logic ev_ok, ev_brk, ev_exc, ev_int, ev_any;
	logic gw_en;
	logic [4:0] gw_a;
	logic [31:0] gw_d;

	function automatic logic [31:0] rd_gpr(input logic [4:0] idx);
		return (idx == 5'h00) ? 32'h00000000 : gpr_q[idx];
	endfunction

	assign op = ir_q[FLD_OP_LSB +: 6];
	assign f_rd = ir_q[FLD_RD_LSB +: 5];
	assign f_ra = ir_q[FLD_RA_LSB +: 5];
	assign f_rb = ir_q[FLD_RB_LSB +: 5];
	assign sidx = ir_q[13:0];
	assign va = rd_gpr(f_ra);
	assign vb = rd_gpr(f_rb);
	assign vd = rd_gpr(f_rd);
	assign imm32 = imm_hi_valid_q ? {imm_hi_q, ir_q[15:0]} : sext16(ir_q[15:0]);
	assign jv = (op == OP_JUMP_REG || op == OP_COND_REG) ? vb : imm32;
	assign in_exec = (state_q == S_EXEC);

	always_comb
	begin
		spr_val = 32'h00000000;
		case (sidx)
			SPR_PC: spr_val = pc_q;
			SPR_MSR: spr_val = msr_q;
			SPR_EAR: spr_val = fault_address_in;
			SPR_ESR: spr_val = fault_cause_in;
			SPR_FSR: spr_val = {27'h0000000, fsr_q};
			SPR_BTR: spr_val = btr_q;
			default:
				if (sidx[13:4] == SPR_PVR_BASE[13:4] && {1'b0, sidx[3:0]} < PVR_IMPL)
					spr_val = VERSION_WORDS[sidx[3:0]];
		endcase
	end

	always_comb
	begin
		x_wen = 1'b0;
		x_wd = 32'h00000000;
		x_jump = 1'b0;
		x_delay = 1'b0;
		x_target = pc_q + jv;
		x_msr_wr = 1'b0;
		x_msr_val = 32'h00000000;
		x_msr_mask = 32'h00000000;
		x_carry_wr = 1'b0;
		x_carry_val = msr_q[MSR_C];
		x_mem = 1'b0;
		x_store = op[MEM_STORE_BIT];
		x_addr = va + (op[MEM_IMM_BIT] ? imm32 : vb);
		x_fsr_wr = 1'b0;
		x_esr_clr = 1'b0;
		x_prefix = 1'b0;
		case (op)
			OP_SPECIAL:
				case (ir_q[15:14])
					SPC_MTS:
					begin
						if (sidx == SPR_MSR)
						begin
							x_msr_wr = 1'b1;
							x_msr_val = va;
							x_msr_mask = MSR_RW_MASK;
							x_carry_wr = 1'b1;
							x_carry_val = va[MSR_C];
						end
						x_fsr_wr = (sidx == SPR_FSR);
					end
					SPC_MFS:
					begin
						x_wen = 1'b1;
						x_wd = spr_val;
					end
					SPC_BITS:
					begin
						x_wen = 1'b1;
						x_wd = msr_q;
						x_msr_wr = 1'b1;
						x_msr_mask = {18'h00000, sidx} & MSR_RW_MASK;
						x_msr_val = (f_ra == SPC_CLEAR_FLD) ? 32'h00000000 : 32'hFFFFFFFF;
						x_carry_wr = sidx[MSR_C];
						x_carry_val = (f_ra != SPC_CLEAR_FLD);
					end
					default: ;
				endcase
			OP_JUMP_REG, OP_JUMP_IMM:
			begin
				x_target = f_ra[JF_ABS] ? jv : pc_q + jv;
				x_jump = !f_ra[JF_DELAY];
				x_delay = f_ra[JF_DELAY];
				x_wen = f_ra[JF_LINK];
				x_wd = pc_q;
				if (f_ra == JF_BREAK)
				begin
					x_msr_wr = 1'b1;
					x_msr_mask = 32'h1 << MSR_BIP;
					x_msr_val = 32'hFFFFFFFF;
				end
			end
			OP_COND_REG, OP_COND_IMM:
			begin
				x_jump = cond_met(f_rd[2:0], va) && !f_rd[CF_DELAY];
				x_delay = cond_met(f_rd[2:0], va) && f_rd[CF_DELAY];
			end
			OP_RETURN:
			begin
				x_target = va + imm32;
				x_delay = 1'b1;
				x_msr_wr = 1'b1;
				case (f_rd)
					RET_INT:
					begin
						x_msr_mask = 32'h1 << MSR_IE;
						x_msr_val = 32'hFFFFFFFF;
					end
					RET_BRK: x_msr_mask = 32'h1 << MSR_BIP;
					RET_EXC:
					begin
						x_msr_mask = (32'h1 << MSR_EE) | (32'h1 << MSR_EIP);
						x_msr_val = 32'h1 << MSR_EE;
						x_esr_clr = 1'b1;
					end
					default: x_msr_wr = 1'b0;
				endcase
			end
			OP_OR_I, OP_AND_I, OP_XOR_I, OP_ANDN_I:
			begin
				x_wen = 1'b1;
				case (op[1:0])
					2'h0: x_wd = va | imm32;
					2'h1: x_wd = va & imm32;
					2'h2: x_wd = va ^ imm32;
					default: x_wd = va & ~imm32;
				endcase
			end
			OP_PREFIX: x_prefix = 1'b1;
			default: x_mem = (op[5:4] == MEM_CLASS) && (op[1:0] != SZ_BAD);
		endcase
	end

	// ----------------------------------------
	// Events at instruction boundaries
	// ----------------------------------------
	// Events wait while a delay slot, a prefix or a staged status write is open,
	// so the return address and the status bits seen by a handler are consistent.
	assign ev_ok = (state_q == S_NEXT) && !dly_pend_q && !imm_hi_valid_q && !stage_valid_q;
	assign ev_brk = ev_ok && pin_sync_q[0] && !msr_q[MSR_BIP];
	assign ev_exc = ev_ok && !ev_brk && USE_EXCEPTIONS && exc_pend_q && msr_q[MSR_EE]
		&& !msr_q[MSR_EIP];
	assign ev_int = ev_ok && !ev_brk && !ev_exc && pin_sync_q[1] && msr_q[MSR_IE];
	assign ev_any = ev_brk || ev_exc || ev_int;
	assign ev_vec = ev_brk ? VEC_BRK : (ev_exc ? VEC_EXC : VEC_INT);
	assign pc_after = x_jump ? x_target : (dly_pend_q ? dly_target_q : pc_q + PC_STEP);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_comb
	begin
		gw_en = 1'b0;
		gw_a = f_rd;
		gw_d = x_wd;
		if (in_exec && x_wen)
			gw_en = 1'b1;
		else if (state_q == S_MEM && dmem_ack_in && !dmem_we_q)
		begin
			gw_en = 1'b1;
			gw_d = load_extract(dmem_rdata_in, dmem_addr_q[1:0], op[1:0]);
		end
		else if (ev_any)
		begin
			gw_en = 1'b1;
			gw_a = ev_brk ? GPR_BRK_RET : (ev_exc ? GPR_EXC_RET : GPR_INT_RET);
			gw_d = pc_q;
		end
		if (gw_a == 5'h00)
			gw_en = 1'b0;
	end

	// No reset here: only a configuration load clears the file.
	always_ff @(posedge clk_in)
	begin
		if (pin_sync_q[2])
			for (int i = 0; i < 32; i++)
				gpr_q[i] <= 32'h00000000;
		else if (gw_en)
			gpr_q[gw_a] <= gw_d;
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= S_NEXT;
			pc_q <= PC_RESET;
			npc_q <= PC_RESET;
			ir_q <= 32'h00000000;
			imem_req_q <= 1'b0;
			dly_pend_q <= 1'b0;
			dly_target_q <= 32'h00000000;
			imm_hi_q <= 16'h0000;
			imm_hi_valid_q <= 1'b0;
		end
		else
			unique case (state_q)
				S_NEXT:
					if (ev_any)
						pc_q <= ev_vec;
					else
					begin
						imem_req_q <= 1'b1;
						state_q <= S_FETCH;
					end
				S_FETCH:
					if (imem_ack_in)
					begin
						ir_q <= imem_data_in;
						imem_req_q <= 1'b0;
						state_q <= S_EXEC;
					end
				S_EXEC:
				begin
					dly_pend_q <= x_delay;
					if (x_delay)
						dly_target_q <= x_target;
					imm_hi_valid_q <= x_prefix;
					if (x_prefix)
						imm_hi_q <= ir_q[15:0];
					if (x_mem)
					begin
						npc_q <= pc_after;
						state_q <= S_MEM;
					end
					else
					begin
						pc_q <= pc_after;
						state_q <= S_NEXT;
					end
				end
				S_MEM:
					if (dmem_ack_in)
					begin
						pc_q <= npc_q;
						state_q <= S_NEXT;
					end
			endcase
	end

	// ----------------------------------------
	// Data memory port
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dmem_req_q <= 1'b0;
			dmem_we_q <= 1'b0;
			dmem_addr_q <= 32'h00000000;
			dmem_wdata_q <= 32'h00000000;
			dmem_be_q <= 4'h0;
		end
		else if (in_exec && x_mem)
		begin
			dmem_req_q <= 1'b1;
			dmem_we_q <= x_store;
			dmem_addr_q <= x_addr;
			dmem_be_q <= store_lanes(x_addr[1:0], op[1:0]);
			case (op[1:0])
				SZ_BYTE: dmem_wdata_q <= {4{vd[7:0]}};
				SZ_HALF: dmem_wdata_q <= {2{vd[15:0]}};
				default: dmem_wdata_q <= vd;
			endcase
		end
		else if (state_q == S_MEM && dmem_ack_in)
			dmem_req_q <= 1'b0;
	end

	// ----------------------------------------
	// Status word
	// ----------------------------------------
	always_comb
	begin
		msr_d = msr_q;
		if (stage_valid_q)
			msr_d = (msr_q & ~stage_mask_q) | (stage_val_q & stage_mask_q);
		if (in_exec && x_carry_wr)
			msr_d[MSR_C] = x_carry_val;
		if (ev_brk)
			msr_d[MSR_BIP] = 1'b1;
		if (ev_exc)
		begin
			msr_d[MSR_EIP] = 1'b1;
			msr_d[MSR_EE] = 1'b0;
		end
		if (ev_int)
			msr_d[MSR_IE] = 1'b0;
		if (div_zero_in)
			msr_d[MSR_DZ] = 1'b1;
		if (stream_mismatch_in)
			msr_d[MSR_FSLERR] = 1'b1;
		msr_d[30:11] = 20'h00000;
		msr_d[MSR_PVR] = PVR_FLAG;
		msr_d[MSR_CC] = msr_d[MSR_C];
	end

	always_ff @(posedge clk_in or negedge rst_b)
	begin
		if (!rst_b)
		begin
			msr_q <= MSR_RESET | ({31'h00000000, PVR_FLAG} << MSR_PVR);
			stage_valid_q <= 1'b0;
			stage_val_q <= 32'h00000000;
			stage_mask_q <= 32'h00000000;
		end
		else
		begin
			msr_q <= msr_d;
			stage_valid_q <= in_exec && x_msr_wr;
			stage_val_q <= x_msr_val;
			stage_mask_q <= x_msr_mask;
		end
	end

	// ----------------------------------------
	// Float status, slot target and fault cause clear
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fsr_q <= 5'h00;
			btr_q <= 32'h00000000;
			esr_clear_q <= 1'b0;
			exc_pend_q <= 1'b0;
		end
		else
		begin
			if (in_exec && x_fsr_wr)
				fsr_q <= va[4:0];
			if (in_exec && x_delay && !msr_q[MSR_EIP])
				btr_q <= x_target;
			esr_clear_q <= in_exec && x_esr_clr;
			exc_pend_q <= exc_req_in || (exc_pend_q && !ev_exc);
		end
	end

	assign imem_req_out = imem_req_q;
	assign imem_addr_out = pc_q;
	assign dmem_req_out = dmem_req_q;
	assign dmem_we_out = dmem_we_q;
	assign dmem_addr_out = dmem_addr_q;
	assign dmem_wdata_out = dmem_wdata_q;
	assign dmem_be_out = dmem_be_q;
	assign esr_clear_out = esr_clear_q;
	assign pc_out = pc_q;
	assign msr_out = msr_q;
	assign fsr_out = fsr_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b);

	r0_write_a: assert property (gw_en |-> gw_a != 5'h00)
		else $error("register zero was written");
	cc_mirror_a: assert property (msr_q[MSR_CC] == msr_q[MSR_C])
		else $error("carry copy differs from carry");
	carry_now_a: assert property (in_exec && x_carry_wr
		|=> msr_q[MSR_C] == $past(x_carry_val))
		else $error("carry write not seen at next edge");
	msr_late_a: assert property (in_exec && x_msr_wr && x_msr_mask[5]
		|=> msr_q[5] == $past(msr_q[5]) ##1 msr_q[5] == $past(x_msr_val[5], 2))
		else $error("status write timing wrong");
	mts_pc_a: assert property (in_exec && op == OP_SPECIAL && ir_q[15:14] == SPC_MTS
		&& !dly_pend_q |=> pc_q == $past(pc_q) + PC_STEP)
		else $error("move to special altered the counter");
	mfs_pc_a: assert property (in_exec && op == OP_SPECIAL && ir_q[15:14] == SPC_MFS
		&& sidx == SPR_PC && f_rd != 5'h00 |-> gw_en && gw_d == pc_q)
		else $error("counter read returned wrong address");
	break_flag_a: assert property (in_exec && op == OP_JUMP_IMM && f_ra == JF_BREAK
		|=> pc_q == $past(imm32) ##1 msr_q[MSR_BIP])
		else $error("break jump failed");
	exc_ret_a: assert property (in_exec && op == OP_RETURN && f_rd == RET_EXC
		|=> esr_clear_out ##1 (msr_q[MSR_EE] && !msr_q[MSR_EIP]))
		else $error("exception return status wrong");
	cond_taken_a: assert property (in_exec && op == OP_COND_REG && !f_rd[CF_DELAY]
		&& cond_met(f_rd[2:0], va) |=> pc_q == $past(pc_q) + $past(vb))
		else $error("register branch target wrong");
	load_zero_a: assert property (state_q == S_MEM && dmem_ack_in && !dmem_we_q
		&& op[1:0] == SZ_BYTE |-> gw_d[31:8] == 24'h000000)
		else $error("byte load upper bits not zero");
endmodule
`default_nettype wire

// File: test/sbsd_mem_model.sv
// Fetch and data memory model that answers the execute core.
`timescale 1ns/1ps
`default_nettype none
module sbsd_mem_model
(
	// Clock
	input wire logic clk_in,
	// Fetch side
	input wire logic imem_req_in,
	input wire logic [31:0] imem_addr_in,
	output logic imem_ack_out,
	output logic [31:0] imem_data_out,
	// Data side
	input wire logic dmem_req_in,
	input wire logic dmem_we_in,
	input wire logic [31:0] dmem_addr_in,
	input wire logic [31:0] dmem_wdata_in,
	input wire logic [3:0] dmem_be_in,
	output logic dmem_ack_out,
	output logic [31:0] dmem_rdata_out
);
	logic [31:0] rom [64];
	logic [31:0] ram [64];
	initial
	begin
		imem_ack_out = 1'b0;
		dmem_ack_out = 1'b0;
		imem_data_out = 32'h00000000;
		dmem_rdata_out = 32'h00000000;
	end
	// Answers one cycle late; idle data flips so a stale word never looks fresh.
	always @(posedge clk_in)
	begin
		imem_ack_out <= imem_req_in && !imem_ack_out;
		imem_data_out <= (imem_req_in && !imem_ack_out) ? rom[imem_addr_in[7:2]] : ~imem_data_out;
		dmem_ack_out <= dmem_req_in && !dmem_ack_out;
		dmem_rdata_out <= (dmem_req_in && !dmem_ack_out) ? ram[dmem_addr_in[7:2]] : ~dmem_rdata_out;
		if (dmem_req_in && dmem_ack_out && dmem_we_in)
			for (int i = 0; i < 4; i++)
				if (dmem_be_in[i])
					ram[dmem_addr_in[7:2]][8*i+:8] <= dmem_wdata_in[8*i+:8];
	end
endmodule
`default_nettype wire

// File: test/testbench.sv
// Bench that runs a short program through the execute core and checks its effects.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_in, rst_b_in, cfg_load_in, dz_in, sm_in;
	logic ireq, iack, dreq, dwe, dack;
	logic [31:0] iaddr, idata, daddr, dwdata, drdata, pc, machine_state_word;
	logic [3:0] dbe;
	logic esr_clr, brk_in;
	logic [4:0] float_status_reg;
	int esr_pulses;
	int num_errors;
	int comparisons;
	sbsd_core u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .cfg_load_in(cfg_load_in),
		.imem_req_out(ireq), .imem_addr_out(iaddr), .imem_ack_in(iack), .imem_data_in(idata),
		.dmem_req_out(dreq), .dmem_we_out(dwe), .dmem_addr_out(daddr), .dmem_wdata_out(dwdata),
		.dmem_be_out(dbe), .dmem_ack_in(dack), .dmem_rdata_in(drdata), .ext_brk_in(brk_in),
		.irq_in(1'b0), .exc_req_in(1'b0), .div_zero_in(dz_in), .stream_mismatch_in(sm_in),
		.fault_address_in(32'h00000ABC), .fault_cause_in(32'h00000000), .esr_clear_out(esr_clr),
		.pc_out(pc), .msr_out(machine_state_word), .fsr_out(float_status_reg));
	sbsd_mem_model u_mem (.clk_in(clk_in), .imem_req_in(ireq), .imem_addr_in(iaddr),
		.imem_ack_out(iack), .imem_data_out(idata), .dmem_req_in(dreq), .dmem_we_in(dwe),
		.dmem_addr_in(daddr), .dmem_wdata_in(dwdata), .dmem_be_in(dbe), .dmem_ack_out(dack),
		.dmem_rdata_out(drdata));
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// The clear request is a one-cycle pulse, so it is counted rather than sampled once.
	always @(negedge clk_in)
	begin
		if (esr_clr === 1'b1)
			esr_pulses++;
	end
	function automatic logic [31:0] ins(logic [5:0] o, logic [4:0] d, logic [4:0] a,
		logic [15:0] m);
		return {o, d, a, m};
	endfunction
	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// The first word only jumps, so the register clear can finish before any write.
	task automatic load_program();
		logic [31:0] p [36];
		p = '{ins(6'h2E, 0, 0, 16'h0004), ins(6'h28, 1, 0, 16'h1234), ins(6'h2A, 2, 1, 16'hFFFF),
			ins(6'h3E, 2, 0, 16'h0040), ins(6'h25, 3, 0, 16'h0004), ins(6'h25, 4, 0, 16'h8001),
			ins(6'h25, 5, 0, 16'h8000), ins(6'h3E, 4, 0, 16'h0044), ins(6'h3E, 5, 0, 16'h0048),
			ins(6'h2E, 6, 20, 16'h0008), ins(6'h28, 7, 0, 16'h0005), ins(6'h3E, 6, 0, 16'h004C),
			ins(6'h3E, 7, 0, 16'h0050), ins(6'h2F, 1, 0, 16'h0008), ins(6'h2F, 0, 0, 16'h0008),
			ins(6'h28, 7, 0, 16'h0009), ins(6'h3E, 7, 0, 16'h0054), ins(6'h38, 8, 0, 16'h0042),
			ins(6'h3E, 8, 0, 16'h0058), ins(6'h28, 0, 0, 16'h0007), ins(6'h3E, 0, 0, 16'h005C),
			ins(6'h25, 9, 1, 16'h0004), ins(6'h25, 10, 0, 16'h8003), ins(6'h3E, 9, 0, 16'h0060),
			ins(6'h3E, 10, 0, 16'h0064), ins(6'h28, 11, 0, 16'h0013), ins(6'h28, 12, 0, 16'h0020),
			ins(6'h28, 13, 0, 16'h0008), ins(6'h25, 0, 11, 16'hC007), ins(6'h27, 1, 11, 16'h6800),
			ins(6'h25, 0, 0, 16'hC007), ins(6'h25, 0, 12, 16'hC001), ins(6'h2D, 20, 0, 16'h008C),
			ins(6'h28, 0, 0, 16'h0000), ins(6'h25, 0, 0, 16'hC007), ins(6'h2E, 0, 0, 16'h0000)};
		foreach (p[i]) u_mem.rom[i] = p[i];
	endtask
	task automatic test_reset();
		chk("pc", 32'h00000000, pc);
		chk("msr", 32'h00000000, machine_state_word);
	endtask
	task automatic test_status();
		chk("logical_xor_immed", 32'hFFFFEDCB, u_mem.ram[16]);
		chk("msr_rd", 32'h80000004, u_mem.ram[17]);
		chk("pc_rd", 32'h00000018, u_mem.ram[18]);
		chk("clr_old", 32'h80000004, u_mem.ram[24]);
		chk("msr_end", 32'h00000000, machine_state_word);
		chk("fault", 32'h00000ABC, u_mem.ram[25]);
	endtask
	task automatic test_flow();
		chk("link", 32'h00000024, u_mem.ram[19]);
		chk("slot", 32'h00000005, u_mem.ram[20]);
		chk("cond", 32'h00000005, u_mem.ram[21]);
		chk("lbu", 32'h000000ED, u_mem.ram[22]);
		chk("r0", 32'h00000000, u_mem.ram[23]);
	endtask
	task automatic test_flags();
		dz_in = 1'b1;
		sm_in = 1'b1;
		@(negedge clk_in);
		dz_in = 1'b0;
		sm_in = 1'b0;
		repeat (3) @(negedge clk_in);
		chk("flags", 32'h00000170, machine_state_word);
	endtask
	// Skipped words rewrite float status with zero, so a missed branch shows up there.
	task automatic test_special();
		chk("fsr", 32'h00000013, {27'h0000000, float_status_reg});
		chk("msr_ret", 32'h00000120, machine_state_word);
		chk("esr_clr", 32'h00000001, esr_pulses);
	endtask
	task automatic test_break();
		brk_in = 1'b1;
		repeat (10) @(negedge clk_in);
		brk_in = 1'b0;
		chk("brk", 32'h00000178, machine_state_word);
	endtask
	task automatic wait_pc(logic [31:0] addr);
		int n = 0;
		while (pc !== addr && n < 3000)
		begin
			@(negedge clk_in);
			n++;
		end
		chk("pc_end", addr, pc);
	endtask
	initial
	begin
		rst_b_in = 1'b0;
		cfg_load_in = 1'b1;
		brk_in = 1'b0;
		dz_in = 1'b0;
		sm_in = 1'b0;
		num_errors = 0;
		comparisons = 0;
		esr_pulses = 0;
		load_program();
		repeat (3) @(negedge clk_in);
		test_reset();
		rst_b_in = 1'b1;
		repeat (4) @(negedge clk_in);
		cfg_load_in = 1'b0;
		wait_pc(32'h00000064);
		repeat (4) @(negedge clk_in);
		test_status();
		test_flow();
		wait_pc(32'h0000008C);
		repeat (4) @(negedge clk_in);
		test_special();
		test_flags();
		test_break();
		report_and_stop();
	end
	initial
	begin
		#100000;
		num_errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
